// ---- src/sci_break_idle_transmit.sv ----
// Break and idle character generator of an asynchronous serial transmitter
// Contract
// - Setting and then clearing the break request bit before the break's last bit time sends exactly one break character.
// - A break lasts 10 bit times with the word length bit clear and 11 with it set.
// - While the break request bit stays set, break characters follow one another.
// - Disabling then re-enabling the transmitter requests an idle character before anything else.
// - A break requested right after an idle request always has its nominal length.
`include "sci_brk_cfg.svh"
module sci_break_idle_transmit
  import sci_brk_pkg::*;
(
  // System clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Software control bits (serial_control_two)
  input wire logic break_request_bit,
  input wire logic transmitter_enable_bit,
  input wire logic word_length_bit,
  // Link clock, one edge per bit time
  input wire logic link_clk,
  // Line and status
  output logic tx_data_out,
  output logic tx_busy
);
  logic [1:0] rst_sys_r;
  logic [1:0] rst_link_r;
  logic rst_sys_n;
  logic rst_link_n;
  link_state_t state_r;
  link_state_t state_nxt;
  logic [3:0] bit_cnt_r;
  logic [3:0] frame_len_r;
  logic brk_pend_r;
  logic idle_pend_r;
  logic last_bit;
  logic start_brk;
  logic start_idle;
  logic tx_line_r;
  logic link_busy_r;
  logic [1:0] busy_s_r;

  xing_if x ();

  // Reset release synchronisers, one per clock domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sys_r <= `SYNC_RST;
    end else begin
      rst_sys_r <= {rst_sys_r[0], 1'b1};
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_link_r <= `SYNC_RST;
    end else begin
      rst_link_r <= {rst_link_r[0], 1'b1};
    end
  end

  assign rst_sys_n = rst_sys_r[1];
  assign rst_link_n = rst_link_r[1];

  // Control crossing into the link domain
  ctrl_cross u_cross (
    .clk(clk),
    .rst_sys_n(rst_sys_n),
    .break_request_bit(break_request_bit),
    .transmitter_enable_bit(transmitter_enable_bit),
    .word_length_bit(word_length_bit),
    .link_clk(link_clk),
    .rst_link_n(rst_link_n),
    .x(x.src)
  );

  // Last bit time of the character in progress
  assign last_bit = (bit_cnt_r == frame_len_r - 4'h1);

  // Next state; an idle request always goes ahead of a break
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      LS_OFF: begin
        // Wait for the re-enable idle request too, so a queued break cannot slip ahead of it
        if (x.te_on && idle_pend_r) begin
          state_nxt = LS_MARK;
        end
      end
      LS_MARK: begin
        if (idle_pend_r) begin
          state_nxt = LS_IDLE;
        end else if (brk_pend_r) begin
          state_nxt = LS_BREAK;
        end
      end
      LS_IDLE, LS_BREAK: begin
        if (last_bit) begin
          if (idle_pend_r) begin
            state_nxt = LS_IDLE;
          end else if (brk_pend_r || (state_r == LS_BREAK && x.brk_hold)) begin
            state_nxt = LS_BREAK;
          end else begin
            state_nxt = LS_MARK;
          end
        end
      end
    endcase
    if (!x.te_on) begin
      state_nxt = LS_OFF;
    end
  end

  // A character starts when the state enters it or restarts it after the last bit
  assign start_brk = (state_nxt == LS_BREAK) && (state_r != LS_BREAK || last_bit);
  assign start_idle = (state_nxt == LS_IDLE) && (state_r != LS_IDLE || last_bit);

  // Sequencer state
  always_ff @(posedge link_clk or negedge rst_link_n) begin
    if (!rst_link_n) begin
      state_r <= LS_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Bit time counter; length latched at the start so a late word length change
  // cannot stretch or cut the character in progress
  always_ff @(posedge link_clk or negedge rst_link_n) begin
    if (!rst_link_n) begin
      bit_cnt_r <= `BIT_CNT_RST;
      frame_len_r <= `BRK_LEN_SHORT;
    end else if (start_brk || start_idle) begin
      bit_cnt_r <= `BIT_CNT_RST;
      frame_len_r <= frame_len_f(x.long_word);
    end else if (state_r == LS_BREAK || state_r == LS_IDLE) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end else begin
      bit_cnt_r <= `BIT_CNT_RST;
    end
  end

  // Pending break: one per set of the request bit; a new request wins over the clear
  always_ff @(posedge link_clk or negedge rst_link_n) begin
    if (!rst_link_n) begin
      brk_pend_r <= 1'b0;
    end else if (x.brk_evt) begin
      brk_pend_r <= 1'b1;
    end else if (start_brk) begin
      brk_pend_r <= 1'b0;
    end
  end

  // Pending idle: consumed when the idle character starts, new request wins
  always_ff @(posedge link_clk or negedge rst_link_n) begin
    if (!rst_link_n) begin
      idle_pend_r <= 1'b0;
    end else if (x.idle_evt) begin
      idle_pend_r <= 1'b1;
    end else if (start_idle) begin
      idle_pend_r <= 1'b0;
    end
  end

  // Line driver: space for a whole break, mark otherwise; an idle with no
  // activity after it lets the break start on a clean bit boundary
  always_ff @(posedge link_clk or negedge rst_link_n) begin
    if (!rst_link_n) begin
      tx_line_r <= `LINE_MARK;
    end else if (state_nxt == LS_BREAK) begin
      tx_line_r <= `LINE_SPACE;
    end else begin
      tx_line_r <= `LINE_MARK;
    end
  end

  assign tx_data_out = tx_line_r;

  // Activity flag in the link domain
  always_ff @(posedge link_clk or negedge rst_link_n) begin
    if (!rst_link_n) begin
      link_busy_r <= 1'b0;
    end else begin
      link_busy_r <= (state_nxt == LS_BREAK) || (state_nxt == LS_IDLE) || brk_pend_r || idle_pend_r;
    end
  end

  // Activity flag carried back to the system domain
  always_ff @(posedge clk or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      busy_s_r <= `SYNC_RST;
    end else begin
      busy_s_r <= {busy_s_r[0], link_busy_r};
    end
  end

  assign tx_busy = busy_s_r[1];

  // Checks on the link sequencer
  property p_brk_short_len;
    @(posedge link_clk) disable iff (!rst_link_n || !x.te_on)
      (start_brk && !x.long_word) |=> (bit_cnt_r == 4'h0) ##9 (bit_cnt_r == 4'h9 && last_bit);
  endproperty
  a_brk_short_len: assert property (p_brk_short_len) else $error("short break not 10 bit times");

  property p_brk_long_len;
    @(posedge link_clk) disable iff (!rst_link_n || !x.te_on)
      (start_brk && x.long_word) |=> (bit_cnt_r == 4'h0) ##10 (bit_cnt_r == 4'hA && last_bit);
  endproperty
  a_brk_long_len: assert property (p_brk_long_len) else $error("long break not 11 bit times");

  property p_brk_line_low;
    @(posedge link_clk) disable iff (!rst_link_n || !x.te_on)
      (start_brk && x.te_on) |=> (!tx_data_out)[*8];
  endproperty
  a_brk_line_low: assert property (p_brk_line_low) else $error("line not low during break");

  property p_brk_from_mark;
    @(posedge link_clk) disable iff (!rst_link_n)
      (state_r == LS_MARK && brk_pend_r && !idle_pend_r && x.te_on)
      |=> (state_r == LS_BREAK && bit_cnt_r == 4'h0 && !tx_data_out);
  endproperty
  a_brk_from_mark: assert property (p_brk_from_mark) else $error("pending break not started");

  property p_brk_repeat;
    @(posedge link_clk) disable iff (!rst_link_n)
      (state_r == LS_BREAK && last_bit && x.brk_hold && !idle_pend_r && x.te_on)
      |=> (state_r == LS_BREAK && bit_cnt_r == 4'h0);
  endproperty
  a_brk_repeat: assert property (p_brk_repeat) else $error("held break not repeated");

  property p_brk_single;
    @(posedge link_clk) disable iff (!rst_link_n)
      (state_r == LS_BREAK && last_bit && !x.brk_hold && !brk_pend_r && !idle_pend_r && x.te_on)
      |=> (state_r == LS_MARK && tx_data_out);
  endproperty
  a_brk_single: assert property (p_brk_single) else $error("extra break after release");

  property p_idle_first;
    @(posedge link_clk) disable iff (!rst_link_n)
      (state_r == LS_MARK && idle_pend_r && x.te_on) |=> (state_r == LS_IDLE && tx_data_out);
  endproperty
  a_idle_first: assert property (p_idle_first) else $error("idle not sent before next character");

  property p_idle_then_brk;
    @(posedge link_clk) disable iff (!rst_link_n)
      (state_r == LS_IDLE && last_bit && brk_pend_r && !idle_pend_r && x.te_on && !x.long_word)
      |=> (state_r == LS_BREAK && bit_cnt_r == 4'h0 && frame_len_r == `BRK_LEN_SHORT);
  endproperty
  a_idle_then_brk: assert property (p_idle_then_brk) else $error("break after idle not nominal");

  property p_te_off_mark;
    @(posedge link_clk) disable iff (!rst_link_n)
      !x.te_on |=> (state_r == LS_OFF && tx_data_out);
  endproperty
  a_te_off_mark: assert property (p_te_off_mark) else $error("line not at mark while disabled");

  property p_brk_whole_low;
    @(posedge link_clk) disable iff (!rst_link_n)
      (state_r == LS_BREAK) |-> !tx_data_out;
  endproperty
  a_brk_whole_low: assert property (p_brk_whole_low) else $error("line high inside a break");

  property p_idle_line_high;
    @(posedge link_clk) disable iff (!rst_link_n)
      (state_r == LS_IDLE) |-> tx_data_out;
  endproperty
  a_idle_line_high: assert property (p_idle_line_high) else $error("line low inside an idle");

  property p_off_to_idle;
    @(posedge link_clk) disable iff (!rst_link_n)
      (state_r == LS_OFF && x.te_on && idle_pend_r) |=> (state_r == LS_MARK && idle_pend_r);
  endproperty
  a_off_to_idle: assert property (p_off_to_idle) else $error("re-enable not followed by idle");

  property p_off_waits;
    @(posedge link_clk) disable iff (!rst_link_n)
      (state_r == LS_OFF && !idle_pend_r) |=> (state_r == LS_OFF);
  endproperty
  a_off_waits: assert property (p_off_waits) else $error("left disabled state without idle request");

  // Main scenarios
  property p_cov_single_brk;
    @(posedge link_clk) disable iff (!rst_link_n)
      (state_r == LS_BREAK && last_bit && !x.brk_hold) ##1 (state_r == LS_MARK);
  endproperty
  c_cov_single_brk: cover property (p_cov_single_brk);

  property p_cov_chain_brk;
    @(posedge link_clk) disable iff (!rst_link_n)
      (state_r == LS_BREAK && last_bit && x.brk_hold) ##1 (state_r == LS_BREAK);
  endproperty
  c_cov_chain_brk: cover property (p_cov_chain_brk);

  property p_cov_idle_brk;
    @(posedge link_clk) disable iff (!rst_link_n)
      (state_r == LS_IDLE && last_bit) ##1 (state_r == LS_BREAK);
  endproperty
  c_cov_idle_brk: cover property (p_cov_idle_brk);

  property p_cov_long_brk;
    @(posedge link_clk) disable iff (!rst_link_n)
      (state_r == LS_BREAK && bit_cnt_r == 4'hA);
  endproperty
  c_cov_long_brk: cover property (p_cov_long_brk);
endmodule : sci_break_idle_transmit

// ---- src/sci_brk_cfg.svh ----
// Constants for the break and idle transmitter: lengths, line levels, reset values
`ifndef SCI_BRK_CFG_SVH
`define SCI_BRK_CFG_SVH

// Break or idle character length in bit times, word length bit clear
`define BRK_LEN_SHORT 4'hA
// Break or idle character length in bit times, word length bit set
`define BRK_LEN_LONG 4'hB
// Reset value of the transmit line: mark (high)
`define LINE_MARK 1'b1
// Level of the transmit line during a break: space (low)
`define LINE_SPACE 1'b0
// Reset value of the bit counter
`define BIT_CNT_RST 4'h0
// Reset value of a two-stage synchroniser
`define SYNC_RST 2'h0

`endif

// ---- src/sci_brk_pkg.sv ----
// Types and shared decode for the break and idle transmitter
package sci_brk_pkg;
  `include "sci_brk_cfg.svh"

  // Link-side sequencer states
  typedef enum logic [1:0] {
    LS_OFF,
    LS_MARK,
    LS_IDLE,
    LS_BREAK
  } link_state_t;

  // Character length in bit times for the selected word length
  function automatic logic [3:0] frame_len_f(input logic long_word);
    frame_len_f = long_word ? `BRK_LEN_LONG : `BRK_LEN_SHORT;
  endfunction : frame_len_f
endpackage : sci_brk_pkg

// ---- src/xing_if.sv ----
// Control events and levels carried from the system domain into the link domain
interface xing_if;
  logic brk_evt;
  logic idle_evt;
  logic brk_hold;
  logic te_on;
  logic long_word;

  modport src (output brk_evt, output idle_evt, output brk_hold, output te_on, output long_word);
  modport dst (input brk_evt, input idle_evt, input brk_hold, input te_on, input long_word);
endinterface : xing_if

// ---- src/ctrl_cross.sv ----
// Crossing of software control bits from the system clock into the link clock
`include "sci_brk_cfg.svh"
module ctrl_cross
  import sci_brk_pkg::*;
(
  // System domain
  input wire logic clk,
  input wire logic rst_sys_n,
  input wire logic break_request_bit,
  input wire logic transmitter_enable_bit,
  input wire logic word_length_bit,
  // Link domain
  input wire logic link_clk,
  input wire logic rst_link_n,
  xing_if.src x
);
  logic brk_d_r;
  logic te_d_r;
  logic brk_tgl_r;
  logic idle_tgl_r;
  logic [1:0] brk_tgl_s_r;
  logic [1:0] idle_tgl_s_r;
  logic brk_tgl_q_r;
  logic idle_tgl_q_r;
  logic [1:0] hold_s_r;
  logic [1:0] te_s_r;
  logic [1:0] long_s_r;

  // Edge history of the break request and transmitter enable bits in the system domain
  always_ff @(posedge clk or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      brk_d_r <= 1'b0;
      te_d_r <= 1'b0;
    end else begin
      brk_d_r <= break_request_bit;
      te_d_r <= transmitter_enable_bit;
    end
  end

  // Each set of the break bit and each enable of the transmitter flips a toggle
  always_ff @(posedge clk or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      brk_tgl_r <= 1'b0;
      idle_tgl_r <= 1'b0;
    end else begin
      if (break_request_bit && !brk_d_r) begin
        brk_tgl_r <= ~brk_tgl_r;
      end
      if (transmitter_enable_bit && !te_d_r) begin
        idle_tgl_r <= ~idle_tgl_r;
      end
    end
  end

  // Toggle synchronisers plus one stage for edge detection
  always_ff @(posedge link_clk or negedge rst_link_n) begin
    if (!rst_link_n) begin
      brk_tgl_s_r <= `SYNC_RST;
      idle_tgl_s_r <= `SYNC_RST;
      brk_tgl_q_r <= 1'b0;
      idle_tgl_q_r <= 1'b0;
    end else begin
      brk_tgl_s_r <= {brk_tgl_s_r[0], brk_tgl_r};
      idle_tgl_s_r <= {idle_tgl_s_r[0], idle_tgl_r};
      brk_tgl_q_r <= brk_tgl_s_r[1];
      idle_tgl_q_r <= idle_tgl_s_r[1];
    end
  end

  // Level synchronisers for hold, enable and word length
  always_ff @(posedge link_clk or negedge rst_link_n) begin
    if (!rst_link_n) begin
      hold_s_r <= `SYNC_RST;
      te_s_r <= `SYNC_RST;
      long_s_r <= `SYNC_RST;
    end else begin
      hold_s_r <= {hold_s_r[0], break_request_bit};
      te_s_r <= {te_s_r[0], transmitter_enable_bit};
      long_s_r <= {long_s_r[0], word_length_bit};
    end
  end

  // One link cycle pulse per crossed event
  assign x.brk_evt = brk_tgl_s_r[1] ^ brk_tgl_q_r;
  assign x.idle_evt = idle_tgl_s_r[1] ^ idle_tgl_q_r;
  assign x.brk_hold = hold_s_r[1];
  assign x.te_on = te_s_r[1];
  assign x.long_word = long_s_r[1];
endmodule : ctrl_cross

// ---- tb/line_rx.sv ----
// Remote receiver model: measures low runs on the transmit line in bit times
module line_rx (
  // Link clock and reset
  input wire logic link_clk,
  input wire logic rst_n,
  // Observed line
  input wire logic line
);
  timeunit 1ns;
  timeprecision 100ps;
  int runs[$];
  int cur;
  realtime t_fall;

  // Count consecutive space bits mid bit, away from the launching edge
  always @(negedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur = 0;
    end else if (line === 1'b0) begin
      if (cur == 0) t_fall = $realtime;
      cur++; // Whole break is space, stop positions included
    end else if (cur > 0) begin
      runs.push_back(cur);
      cur = 0;
    end
  end
endmodule : line_rx

// ---- tb/sci_break_idle_transmit_tb.sv ----
// Self-checking bench for the break and idle transmitter
module sci_break_idle_transmit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sci_brk_pkg::*;

`define CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin err_total++; \
  $display("BAD %s exp %0d got %0d", nm, e, g); end end

  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b1;
  logic brk = 1'b0;
  logic te = 1'b0;
  logic wl = 1'b0;
  logic tx_data_out;
  logic tx_busy;
  int err_total = 0;
  int checks = 0;
  int seed = 23951;
  int len;
  int run;
  realtime t0;

  // System clock 100 MHz
  initial forever #5 clk = ~clk;

  // Link clock 160 ns, offset in phase
  initial begin
    #37;
    forever #80 link_clk = ~link_clk;
  end

  sci_break_idle_transmit i_dut (
    .clk(clk),
    .rst_n(rst_n),
    .break_request_bit(brk),
    .transmitter_enable_bit(te),
    .word_length_bit(wl),
    .link_clk(link_clk),
    .tx_data_out(tx_data_out),
    .tx_busy(tx_busy)
  );

  line_rx i_rx (
    .link_clk(link_clk),
    .rst_n(rst_n),
    .line(tx_data_out)
  );

  // One clock wide break request
  task pulse_brk;
    @(posedge clk) #1 brk = 1'b1;
    @(posedge clk) #1 brk = 1'b0;
  endtask : pulse_brk

  // Wait for busy to rise and then fall, bounded
  task wait_done;
    int n;
    n = 0;
    while (tx_busy !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (tx_busy !== 1'b0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000) begin
      err_total++;
      $display("BAD busy timeout exp 0 got 1");
    end
    repeat (3) @(posedge link_clk);
    #1;
    `CHK("line idle", 1'b1, tx_data_out) // Mark after every character
  endtask : wait_done

  // Set word length and let it settle in the link domain
  task set_wl(input logic v);
    @(posedge clk) #1 wl = v;
    repeat (4) @(posedge link_clk);
    @(posedge clk) #1;
  endtask : set_wl

  // Verdict and end of run
  task test_done;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // Watchdog well beyond the expected run time
  initial begin
    #800000;
    err_total++;
    $display("BAD watchdog exp done got hang");
    test_done();
  end

  // Main sequence
  initial begin
    #1 rst_n = 1'b0; // A real falling edge so the link domain resets with no link edge yet
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge link_clk);
    #1;
    `CHK("reset line", 1'b1, tx_data_out)
    `CHK("reset busy", 1'b0, tx_busy)
    @(posedge clk) #1 te = 1'b1;
    wait_done();
    i_rx.runs.delete();
    $display("test reset and first idle done");

    // Single break for both word lengths
    for (int i = 0; i < 2; i++) begin
      set_wl(i[0]);
      len = i ? 4'hB : 4'hA;
      pulse_brk();
      wait_done();
      `CHK("break count", 1, i_rx.runs.size())
      `CHK("break length", len, i_rx.runs[0])
      i_rx.runs.delete();
    end
    $display("test single break done");

    // Held request gives back to back breaks with no mark between
    set_wl(1'b0);
    @(posedge clk) #1 brk = 1'b1;
    repeat (25) @(posedge link_clk);
    @(posedge clk) #1 brk = 1'b0;
    wait_done();
    run = i_rx.runs.size() ? i_rx.runs[0] : 0;
    `CHK("held runs", 1, i_rx.runs.size())
    `CHK("held multiple", 0, run % 10)
    `CHK("held at least two", 1, int'(run >= 20))
    i_rx.runs.delete();
    $display("test held break done");

    // Idle request then break with nothing between, random word length
    for (int i = 0; i < 4; i++) begin
      set_wl(1'($random(seed)));
      len = wl ? 4'hB : 4'hA;
      @(posedge clk) #1 te = 1'b0;
      repeat (4) @(posedge link_clk);
      @(posedge clk) #1 te = 1'b1;
      t0 = $realtime;
      pulse_brk();
      wait_done();
      `CHK("idle break count", 1, i_rx.runs.size())
      `CHK("idle break length", len, i_rx.runs[0])
      `CHK("idle before break", 1, int'((i_rx.t_fall - t0) / 160.0 >= len))
      i_rx.runs.delete();
    end
    $display("test idle then break done");
    test_done();
  end
endmodule : sci_break_idle_transmit_tb
